// ===== logic/idr_pkg.sv
// package for the dma channel register block: offsets, field positions, reset values
// assumes an 8-bit isa i/o window with a 4-bit register offset
package idr_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [3:0] IDR_CHAN0_CURRENT_ADDRESS = 4'h0;
	localparam logic [3:0] IDR_CHAN0_TRANSFER_COUNT = 4'h1;
	localparam logic [3:0] IDR_CHAN1_CURRENT_ADDRESS = 4'h2;
	localparam logic [3:0] IDR_CHAN1_TRANSFER_COUNT = 4'h3;
	localparam logic [3:0] IDR_CHAN2_CURRENT_ADDRESS = 4'h4;
	localparam logic [3:0] IDR_CHAN2_TRANSFER_COUNT = 4'h5;
	localparam logic [3:0] IDR_CHAN3_CURRENT_ADDRESS = 4'h6;
	localparam logic [3:0] IDR_CHAN3_TRANSFER_COUNT = 4'h7;
	localparam logic [3:0] IDR_CHANNEL_REQUEST_TC_STATUS = 4'h8;
	localparam logic [3:0] IDR_DMA_OPTION_CONTROL = 4'h8;
	localparam logic [3:0] IDR_BYTE_POINTER_CLEAR = 4'hC;
	// ****************************************
	// field positions and counts
	// ****************************************
	localparam int IDR_STAT_REQ_LSB = 4;
	localparam int IDR_STAT_TC_LSB = 0;
	localparam int IDR_ADDR_SELECT_BIT = 15;
	localparam int IDR_NUM_CHAN = 4;
	localparam int IDR_NUM_WORDS = 8;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] IDR_CMD_RESET = 8'h00;
	localparam logic [7:0] IDR_STAT_RESET = 8'h00;
	localparam logic [15:0] IDR_WORD_RESET = 16'h0000;
	localparam logic IDR_PTR_RESET = 1'b0;

	// command byte, msb first
	typedef struct packed {
		logic ack_polarity;
		logic request_polarity;
		logic extended_write;
		logic rotating_priority;
		logic compressed_timing;
		logic controller_disable;
		logic chan0_address_hold;
		logic memory_copy_enable;
	} idr_cmd_s;
endpackage

// ===== logic/idr_word_mem.sv
// small register file of sixteen-bit address and count words, written a byte at a time
// assumes the caller decodes the bus; read data come out one cycle after rd_en
`timescale 1ns/1ps
module idr_word_mem #(
	parameter int NUM_WORDS = idr_pkg::IDR_NUM_WORDS
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [2:0] idx,
	input wire logic hi,
	input wire logic [7:0] wdata,
	output logic [7:0] rd_byte,
	output logic [NUM_WORDS*16-1:0] words_flat
);
	import idr_pkg::*;

	logic [15:0] word_r [NUM_WORDS];

	// ****************************************
	// storage, one word per entry
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < NUM_WORDS; g++) begin : g_word
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					word_r[g] <= IDR_WORD_RESET;
				end else if (wr_en && idx == 3'(g)) begin
					if (hi) begin
						word_r[g][15:8] <= wdata;
					end else begin
						word_r[g][7:0] <= wdata;
					end
				end
			end
			assign words_flat[g*16 +: 16] = word_r[g];
		end
	endgenerate

	// ****************************************
	// registered read port
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_byte <= 8'h00;
		end else if (rd_en) begin
			rd_byte <= hi ? word_r[idx][15:8] : word_r[idx][7:0];
		end
	end
endmodule // idr_word_mem

// ===== logic/idr_dma_regs.sv
// programming and status registers of a four-channel dma controller
// assumes an 8-bit i/o window synchronous to clk_sys and a transfer engine outside
// Contract
// - address registers reach low byte when pointer is 0, high when 1.
// - count registers reach low byte when pointer is 0, high when 1.
// - status bits 7..4 show pending requests of channels 3..0.
// - status bits 3..0 show terminal count reached on channels 3..0.
// - reading status through the i/o window clears the status bits.
// - same status bits also shown on a separate bus status output.
// - command bit 7 sets ack polarity, bit 6 request polarity; 1 is low.
// - command bit 1 set holds channel 0 address constant during transfers; here the bit is only stored and passed out on option_control.
// - internal byte pointer picks high or low byte of next access.
// - address bit 15 selects internal buffer (1) or external memory (0).
`timescale 1ns/1ps
module idr_dma_regs #(
	parameter int NUM_CHAN = idr_pkg::IDR_NUM_CHAN
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_wr,
	input wire logic io_rd,
	output logic [7:0] io_rdata,
	output logic io_rvalid,
	input wire logic hlda,
	input wire logic [NUM_CHAN-1:0] dreq_pin,
	input wire logic [NUM_CHAN-1:0] ack_grant,
	input wire logic [NUM_CHAN-1:0] tc_event,
	output logic [NUM_CHAN-1:0] dack_pin,
	output logic [NUM_CHAN-1:0] request_active,
	output idr_pkg::idr_cmd_s option_control,
	output logic [7:0] bus_status,
	output logic [NUM_CHAN*16-1:0] chan_address,
	output logic [NUM_CHAN*16-1:0] chan_count,
	output logic [NUM_CHAN-1:0] internal_buffer_select
);
	import idr_pkg::*;

	logic ptr_r;
	logic [7:0] stat_r;
	logic [7:0] stat_rd_r;
	logic from_stat_r;
	logic from_mem_r;
	logic rvalid_r;
	idr_cmd_s cmd_r;
	logic [7:0] mem_byte;
	logic [IDR_NUM_WORDS*16-1:0] words_flat;
	logic wr_ok;
	logic word_hit;
	logic word_wr;
	logic word_rd;
	logic stat_rd;
	logic [7:0] stat_set;

	// ****************************************
	// decode
	// ****************************************
	// writes under hold acknowledge are dropped: the engine owns the words then
	assign wr_ok = io_wr && !hlda;
	assign word_hit = (io_addr[3] == 1'b0);
	assign word_wr = wr_ok && word_hit;
	assign word_rd = io_rd && !io_wr && word_hit;
	assign stat_rd = io_rd && !io_wr && io_addr == IDR_CHANNEL_REQUEST_TC_STATUS;

	// ****************************************
	// byte pointer
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ptr_r <= IDR_PTR_RESET;
		end else if (wr_ok && io_addr == IDR_BYTE_POINTER_CLEAR) begin
			ptr_r <= 1'b0;
		end else if (word_wr || word_rd) begin
			ptr_r <= ~ptr_r;
		end
	end

	// ****************************************
	// address and count words
	// ****************************************
	idr_word_mem #(
		.NUM_WORDS(IDR_NUM_WORDS)
	) u_mem (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_en(word_wr),
		.rd_en(word_rd),
		.idx(io_addr[2:0]),
		.hi(ptr_r),
		.wdata(io_wdata),
		.rd_byte(mem_byte),
		.words_flat(words_flat)
	);

	// ****************************************
	// command register
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cmd_r <= idr_cmd_s'(IDR_CMD_RESET);
		end else if (wr_ok && io_addr == IDR_DMA_OPTION_CONTROL) begin
			cmd_r <= idr_cmd_s'(io_wdata);
		end
	end
	assign option_control = cmd_r;

	// ****************************************
	// per-channel pins, status sources, word views
	// ****************************************
	genvar c;
	generate
		for (c = 0; c < NUM_CHAN; c++) begin : g_chan
			assign request_active[c] = dreq_pin[c] ^ cmd_r.request_polarity;
			assign dack_pin[c] = ack_grant[c] ^ cmd_r.ack_polarity;
			assign stat_set[IDR_STAT_REQ_LSB + c] = request_active[c];
			assign stat_set[IDR_STAT_TC_LSB + c] = tc_event[c];
			assign chan_address[c*16 +: 16] = words_flat[(2*c)*16 +: 16];
			assign chan_count[c*16 +: 16] = words_flat[(2*c+1)*16 +: 16];
			assign internal_buffer_select[c] =
				words_flat[(2*c)*16 + IDR_ADDR_SELECT_BIT];
		end
	endgenerate

	// ****************************************
	// status register
	// ****************************************
	// set wins over the read clear, so an event in the read cycle survives
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stat_r <= IDR_STAT_RESET;
		end else if (stat_rd) begin
			stat_r <= stat_set;
		end else begin
			stat_r <= stat_r | stat_set;
		end
	end
	assign bus_status = stat_r;

	// ****************************************
	// read return
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stat_rd_r <= IDR_STAT_RESET;
			from_stat_r <= 1'b0;
			from_mem_r <= 1'b0;
			rvalid_r <= 1'b0;
		end else begin
			if (stat_rd) begin
				stat_rd_r <= stat_r;
			end
			from_stat_r <= stat_rd;
			from_mem_r <= word_rd;
			rvalid_r <= io_rd && !io_wr;
		end
	end
	// unmapped or write-only offsets read as zero
	assign io_rdata = from_stat_r ? stat_rd_r : (from_mem_r ? mem_byte : 8'h00);
	assign io_rvalid = rvalid_r;

	// ****************************************
	// checks
	// ****************************************
	property p_low_byte;
		@(posedge clk_sys) disable iff (rst)
		(word_wr && !ptr_r) |=> words_flat[$past(io_addr[2:0])*16 +: 8] == $past(io_wdata);
	endproperty
	a_low_byte: assert property (p_low_byte) else $error("low byte not written");

	property p_high_byte;
		@(posedge clk_sys) disable iff (rst)
		(word_wr && ptr_r) |=> words_flat[$past(io_addr[2:0])*16 + 8 +: 8] == $past(io_wdata);
	endproperty
	a_high_byte: assert property (p_high_byte) else $error("high byte not written");

	property p_read_byte;
		@(posedge clk_sys) disable iff (rst)
		(word_rd && !wr_ok) |=> io_rvalid && io_rdata ==
			(($past(ptr_r)) ? words_flat[$past(io_addr[2:0])*16 + 8 +: 8]
			: words_flat[$past(io_addr[2:0])*16 +: 8]);
	endproperty
	a_read_byte: assert property (p_read_byte) else $error("wrong byte read");

	property p_ptr_toggle;
		@(posedge clk_sys) disable iff (rst)
		(word_wr || word_rd) |=> ptr_r != $past(ptr_r);
	endproperty
	a_ptr_toggle: assert property (p_ptr_toggle) else $error("pointer did not flip");

	property p_ptr_clear;
		@(posedge clk_sys) disable iff (rst)
		(wr_ok && io_addr == IDR_BYTE_POINTER_CLEAR) |=> !ptr_r;
	endproperty
	a_ptr_clear: assert property (p_ptr_clear) else $error("pointer not cleared");

	property p_stat_read;
		@(posedge clk_sys) disable iff (rst)
		stat_rd |=> io_rdata == $past(stat_r);
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("status read wrong");

	property p_tc_sticky;
		@(posedge clk_sys) disable iff (rst)
		(tc_event[0] && !stat_rd) ##1 !stat_rd |=> stat_r[IDR_STAT_TC_LSB];
	endproperty
	a_tc_sticky: assert property (p_tc_sticky) else $error("terminal count lost");

	property p_stat_clear;
		@(posedge clk_sys) disable iff (rst)
		(stat_rd && stat_set == 8'h00) |=> stat_r == 8'h00;
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");

	property p_hlda_block;
		@(posedge clk_sys) disable iff (rst)
		(io_wr && hlda) |=> $stable(words_flat) && $stable(cmd_r) && $stable(ptr_r);
	endproperty
	a_hlda_block: assert property (p_hlda_block) else $error("write under hold taken");

	property p_polarity;
		@(posedge clk_sys) disable iff (rst)
		(wr_ok && io_addr == IDR_DMA_OPTION_CONTROL) |=>
			dack_pin == (ack_grant ^ {NUM_CHAN{$past(io_wdata[7])}}) &&
			request_active == (dreq_pin ^ {NUM_CHAN{$past(io_wdata[6])}});
	endproperty
	a_polarity: assert property (p_polarity) else $error("polarity wrong");

	property p_hold;
		@(posedge clk_sys) disable iff (rst)
		(wr_ok && io_addr == IDR_DMA_OPTION_CONTROL) |=>
			option_control.chan0_address_hold == $past(io_wdata[1]) &&
			option_control.memory_copy_enable == $past(io_wdata[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("command bits wrong");

	property p_select;
		@(posedge clk_sys) disable iff (rst)
		(word_wr && ptr_r && io_addr[2:0] == 3'h0) |=>
			internal_buffer_select[0] == $past(io_wdata[7]);
	endproperty
	a_select: assert property (p_select) else $error("buffer select wrong");

	property p_addr_write;
		@(posedge clk_sys) disable iff (rst)
		(word_wr && !io_addr[0]) |=>
			chan_address[$past(io_addr[2:1])*16 + ($past(ptr_r) ? 8 : 0) +: 8] ==
			$past(io_wdata);
	endproperty
	a_addr_write: assert property (p_addr_write) else $error("address byte not written");

	property p_count_write;
		@(posedge clk_sys) disable iff (rst)
		(word_wr && io_addr[0]) |=>
			chan_count[$past(io_addr[2:1])*16 + ($past(ptr_r) ? 8 : 0) +: 8] ==
			$past(io_wdata);
	endproperty
	a_count_write: assert property (p_count_write) else $error("count byte not written");

	property p_rvalid;
		@(posedge clk_sys) disable iff (rst)
		(io_rd && !io_wr) |=> io_rvalid;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");

	property p_rvalid_idle;
		@(posedge clk_sys) disable iff (rst)
		!(io_rd && !io_wr) |=> !io_rvalid;
	endproperty
	a_rvalid_idle: assert property (p_rvalid_idle) else $error("answer without read");

	property p_req_status;
		@(posedge clk_sys) disable iff (rst)
		(request_active != '0) |=>
			(stat_r[IDR_STAT_REQ_LSB +: NUM_CHAN] & $past(request_active)) ==
			$past(request_active);
	endproperty
	a_req_status: assert property (p_req_status) else $error("request not recorded");

	property p_tc_status;
		@(posedge clk_sys) disable iff (rst)
		(tc_event != '0) |=>
			(stat_r[IDR_STAT_TC_LSB +: NUM_CHAN] & $past(tc_event)) == $past(tc_event);
	endproperty
	a_tc_status: assert property (p_tc_status) else $error("terminal count not recorded");

	property p_stat_keep;
		@(posedge clk_sys) disable iff (rst)
		!stat_rd |=> (stat_r & $past(stat_r)) == $past(stat_r);
	endproperty
	a_stat_keep: assert property (p_stat_keep) else $error("status lost without read");

	property p_bus_after_read;
		@(posedge clk_sys) disable iff (rst)
		stat_rd |=> bus_status == $past(stat_set);
	endproperty
	a_bus_after_read: assert property (p_bus_after_read) else $error("bus status wrong");

	property p_cmd_keep;
		@(posedge clk_sys) disable iff (rst)
		!(wr_ok && io_addr == IDR_DMA_OPTION_CONTROL) |=> $stable(cmd_r);
	endproperty
	a_cmd_keep: assert property (p_cmd_keep) else $error("command changed");

	property p_ptr_keep;
		@(posedge clk_sys) disable iff (rst)
		!(wr_ok && io_addr == IDR_BYTE_POINTER_CLEAR) && !word_wr && !word_rd |=> $stable(ptr_r);
	endproperty
	a_ptr_keep: assert property (p_ptr_keep) else $error("pointer moved");

	property p_word_keep;
		@(posedge clk_sys) disable iff (rst)
		!word_wr |=> $stable(words_flat);
	endproperty
	a_word_keep: assert property (p_word_keep) else $error("word changed without write");
endmodule // idr_dma_regs

// ===== testbench/idr_periph_model.sv
// peripheral side model: raw dma request pins
// assumes the bench gives the wanted requests and the sense it programmed
`timescale 1ns/1ps
module idr_periph_model (
	input wire logic [3:0] want,
	input wire logic act_low,
	output logic [3:0] dreq_pin
);
	// ****
	// request pins
	// ****
	// pins follow the programmed sense; a stale sense shows as false requests
	assign dreq_pin = want ^ {4{act_low}};
endmodule // idr_periph_model

// ===== testbench/testbench.sv
// self-checking bench for the dma channel register block
// assumes the design sits alone, driven at the falling edge of clk_sys
`timescale 1ns/1ps
module testbench;
	import idr_pkg::*;
	logic clk_sys, rst, io_wr, io_rd, io_rvalid, hlda, act_low;
	logic [3:0] io_addr, want, ack_grant, tc_event, dreq_pin, dack_pin, request_active, ibs;
	logic [3:0] eibs;
	logic [7:0] io_wdata, io_rdata, bus_status;
	logic [63:0] chan_address, chan_count, ea, ec;
	idr_cmd_s option_control;
	int mismatches = 0, n_compared = 0, seed = 41557, ptr = 0, stat = 0, v, w[8];
	idr_periph_model u_idr_periph_model (.want(want), .act_low(act_low), .dreq_pin(dreq_pin));
	idr_dma_regs u_idr_dma_regs (.clk_sys(clk_sys), .rst(rst), .io_addr(io_addr),
		.io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
		.io_rvalid(io_rvalid), .hlda(hlda), .dreq_pin(dreq_pin), .ack_grant(ack_grant),
		.tc_event(tc_event), .dack_pin(dack_pin), .request_active(request_active),
		.option_control(option_control), .bus_status(bus_status), .chan_address(chan_address),
		.chan_count(chan_count), .internal_buffer_select(ibs));
	// ****
	// helpers
	// ****
	task check(input string n, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task end_of_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// one i/o access; reads are checked against the model, writes update it
	task acc(input bit wr, input bit [3:0] a, input bit [7:0] d);
		int e;
		e = (a < 8) ? (w[a] >> (8 * ptr)) & 8'hFF : (a == 8) ? stat : 0;
		@(negedge clk_sys);
		io_wr = wr;
		io_rd = !wr;
		io_addr = a;
		io_wdata = d;
		@(negedge clk_sys);
		io_wr = 0;
		io_rd = 0;
		if (!wr && e >= 0) check("io_rdata", 256 | e, {io_rvalid, io_rdata});
		if (!wr && a == 8) stat = 0;
		if (wr && hlda) return;
		if (a < 8 && wr) w[a] = ptr ? (w[a] & 8'hFF) | (d << 8) : (w[a] & 16'hFF00) | d;
		if (a < 8) ptr ^= 1;
		if (wr && a == 12) ptr = 0;
	endtask
	// ****
	// clock, watchdog, tests
	// ****
	initial begin
		clk_sys = 0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		mismatches++;
		end_of_test();
	end
	initial begin
		{rst, io_wr, io_rd, hlda, act_low, io_addr, io_wdata} = 0;
		{want, ack_grant, tc_event} = 0;
		w = '{default: 0};
		rst = 1;
		repeat (5) @(negedge clk_sys);
		rst = 0;
		check("chan_address", 0, chan_address);
		check("chan_count", 0, chan_count);
		check("option_control", IDR_CMD_RESET, option_control);
		check("bus_status", IDR_STAT_RESET, bus_status);
		acc(1, 4'hC, 8'h00);
		for (int i = 0; i < 16; i++) acc(1, i >> 1, $random(seed));
		hlda = 1;
		acc(1, 4'h2, 8'h55);
		hlda = 0;
		for (int c = 0; c < 4; c++) begin
			ea[c*16+:16] = 16'(w[2*c]);
			ec[c*16+:16] = 16'(w[2*c+1]);
			eibs[c] = w[2*c][15];
		end
		check("chan_address", ea, chan_address);
		check("internal_buffer_select", eibs, ibs);
		check("chan_count", ec, chan_count);
		acc(1, 4'hC, 8'h00);
		for (int i = 0; i < 16; i++) acc(0, i >> 1, 8'h00);
		acc(1, 4'h0, $random(seed));
		acc(0, 4'h0, 8'h00);
		acc(0, 4'h9, 8'h00);
		acc(0, 4'hF, 8'h00);
		$display("test registers done");
		for (int k = 0; k < 4; k++) begin
			v = ($random(seed) & 8'h3F) | (k << 6);
			acc(1, 4'h8, v[7:0]);
			act_low = v[6];
			want = $random(seed);
			ack_grant = $random(seed);
			repeat (2) @(negedge clk_sys);
			check("option_control", v[7:0], option_control);
			check("dack_pin", ack_grant ^ {4{v[7]}}, dack_pin);
			check("request_active", want, request_active);
		end
		$display("test command done");
		want = 0;
		@(negedge clk_sys);
		stat = -1;
		acc(0, 4'h8, 8'h00);
		v = $random(seed) | 1;
		want = v[3:0];
		tc_event = v[7:4];
		@(negedge clk_sys);
		tc_event = 0;
		want = 0;
		repeat (2) @(negedge clk_sys);
		stat = (v[3:0] << 4) | v[7:4];
		check("bus_status", stat, bus_status);
		acc(0, 4'h8, 8'h00);
		check("bus_status", 0, bus_status);
		acc(0, 4'h8, 8'h00);
		@(negedge clk_sys);
		{io_rd, io_addr, tc_event} = {1'b1, 4'h8, 4'h2};
		@(negedge clk_sys);
		{io_rd, tc_event} = 0;
		check("io_rdata", 256, {io_rvalid, io_rdata});
		check("bus_status", 8'h02, bus_status);
		stat = 2;
		acc(0, 4'h8, 8'h00);
		$display("test status done");
		end_of_test();
	end
endmodule // testbench
